// ==== design/dsc_sequencer.sv ====
// drive sequencing state machine with fieldbus control and status words
// assumes plain flags from ramp, trip and contactor logic; all pass two flops
// Notes on behaviour
// - state reported as 3-bit enumeration
// - lowest numbered exit wins on conflict
// - start disabled to enabled when idle, released
// - start enabled drops back on stop input
// - switched on trips, including contactor timeout
// - switched on to ready when contactor, defluxed
// - switched on/ready back when no request
// - switched on/ready disabled on stop input
// - trip to trip active, quenched to tripped
// - enabled: coast disables, fast stop active
// - enabled back when idle and stopped
// - fast stop ends on timer, coast, zero
// - tripped clears on reset rising, no trip
// - remote mode takes run and trip reset from command word only
// - bit 0 is forward run only
// - bits 1,2,3 ANDed with local inputs
// - bit 7 is the trip reset
// - status 0..3 mirror sequencer outputs
// - status 4,5 echo command or inputs
// - status 6 only in start disabled
// - status 9 remote and comms select
// - status 10 when ramp idle
// - status 11 on torque or current limit
// - unsupported status bits read zero
`timescale 1ns/1ns
module dsc_sequencer #(
	parameter int CONTACTOR_TMO = dsc_pkg::CONTACTOR_TMO_CYC
) (
	input  wire logic              clock,
	input  wire logic              resetn,
	// avalon-mm slave
	input  wire logic [3:0]        address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	output logic [31:0]            readdata,
	output logic                   waitrequest,
	// local sequencing inputs and plant flags (asynchronous)
	input  wire dsc_pkg::dsc_cmd_s localCmd,
	input  wire dsc_pkg::dsc_fb_s  plantFb,
	// sequencer outputs
	output logic [2:0]             seqState,
	output logic [15:0]            statusWord
);
	// two-flop synchronisers for the local and plant flag inputs
	localparam int CW = $bits(dsc_pkg::dsc_cmd_s);
	localparam int FW = $bits(dsc_pkg::dsc_fb_s);
	logic [CW-1:0]        cmdMeta_reg;   // first stage, read only by second
	logic [CW-1:0]        cmdSync_reg;
	logic [FW-1:0]        fbMeta_reg;
	logic [FW-1:0]        fbSync_reg;
	dsc_pkg::dsc_cmd_s    loc;
	dsc_pkg::dsc_fb_s     fb;

	// registers
	logic [15:0]          control_reg;    // drive_control_word
	logic [2:0]           config_reg;     // remote mode, comms select, coast method
	dsc_pkg::dsc_state_e  state_reg;
	dsc_pkg::dsc_state_e  state_next;
	logic                 resetPrev_reg;  // last trip reset level
	logic [31:0]          timer_reg;      // time spent in switched on
	logic                 ack_reg;        // bus answer pending
	logic [15:0]          status_next;

	// synchroniser process
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			cmdMeta_reg <= '0;
			cmdSync_reg <= '0;
			fbMeta_reg  <= '0;
			fbSync_reg  <= '0;
		end
		else
		begin
			cmdMeta_reg <= localCmd;
			cmdSync_reg <= cmdMeta_reg;
			fbMeta_reg  <= plantFb;
			fbSync_reg  <= fbMeta_reg;
		end
	end
	assign loc = dsc_pkg::dsc_cmd_s'(cmdSync_reg);
	assign fb  = dsc_pkg::dsc_fb_s'(fbSync_reg);

	// effective sequencing inputs, local or from the command word
	wire remoteMode = config_reg[dsc_pkg::CF_REMOTE_MODE];
	// bit 0 alone runs; inch request is forced off remotely
	wire runReq     = remoteMode ? control_reg[dsc_pkg::CW_SWITCH_ON]
	                             : loc.forwardMotion;
	wire jogReq     = remoteMode ? 1'b0 : loc.inchRequest;
	wire notCoast   = remoteMode ? (control_reg[dsc_pkg::CW_NOT_COAST] & loc.notCoastStop)
	                             : loc.notCoastStop;
	wire notFast    = remoteMode ? (control_reg[dsc_pkg::CW_NOT_QUICK] & loc.notFastStop)
	                             : loc.notFastStop;
	wire enableReq  = remoteMode ? (control_reg[dsc_pkg::CW_ENABLE_OP] & loc.driveEnable)
	                             : loc.driveEnable;
	wire faultClr   = remoteMode ? control_reg[dsc_pkg::CW_FAULT_CLR]
	                             : loc.faultClear;
	wire anyReq     = runReq | jogReq;
	wire stopInput  = ~notCoast | ~notFast;
	wire resetRise  = faultClr & ~resetPrev_reg;
	// contactor feedback lost counts as a trip from ready onward
	wire tripLive   = fb.trip | ~fb.contactorClosed;
	wire contactTmo = (timer_reg >= CONTACTOR_TMO - 1);
	wire coastMeth  = config_reg[dsc_pkg::CF_COAST_FSTOP];

	// next state; branches ordered by transition number
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			dsc_pkg::ST_START_DISABLED:
			begin
				if (fb.trip)
					state_next = dsc_pkg::ST_TRIP_ACTIVE;
				else if (!anyReq && notFast && notCoast)
					state_next = dsc_pkg::ST_START_ENABLED;
			end
			dsc_pkg::ST_START_ENABLED:
			begin
				if (fb.trip)
					state_next = dsc_pkg::ST_TRIP_ACTIVE;
				else if (stopInput)
					state_next = dsc_pkg::ST_START_DISABLED;
				else if (anyReq)
					state_next = dsc_pkg::ST_SWITCHED_ON;
			end
			dsc_pkg::ST_SWITCHED_ON:
			begin
				if (fb.trip || (!fb.contactorClosed && contactTmo))
					state_next = dsc_pkg::ST_TRIP_ACTIVE;
				else if (stopInput)
					state_next = dsc_pkg::ST_START_DISABLED;
				else if (!anyReq)
					state_next = dsc_pkg::ST_START_ENABLED;
				else if (fb.contactorClosed && fb.defluxed)
					state_next = dsc_pkg::ST_READY;
			end
			dsc_pkg::ST_READY:
			begin
				if (tripLive)
					state_next = dsc_pkg::ST_TRIP_ACTIVE;
				else if (stopInput)
					state_next = dsc_pkg::ST_START_DISABLED;
				else if (!anyReq)
					state_next = dsc_pkg::ST_START_ENABLED;
				else if (enableReq)
					state_next = dsc_pkg::ST_ENABLED;
			end
			dsc_pkg::ST_ENABLED:
			begin
				if (tripLive)
					state_next = dsc_pkg::ST_TRIP_ACTIVE;
				else if (!notCoast)
					state_next = dsc_pkg::ST_START_DISABLED;
				else if (!notFast)
					state_next = dsc_pkg::ST_FSTOP_ACTIVE;
				else if (!anyReq && fb.stopDone)
					state_next = dsc_pkg::ST_START_ENABLED;
				else if (!enableReq)
					state_next = dsc_pkg::ST_READY;
			end
			dsc_pkg::ST_FSTOP_ACTIVE:
			begin
				if (tripLive)
					state_next = dsc_pkg::ST_TRIP_ACTIVE;
				else if (fb.fastStopExpired || coastMeth || fb.atZeroSetpoint)
					state_next = dsc_pkg::ST_START_DISABLED;
			end
			dsc_pkg::ST_TRIP_ACTIVE:
			begin
				if (fb.stackQuenched)
					state_next = dsc_pkg::ST_TRIPPED;
			end
			dsc_pkg::ST_TRIPPED:
			begin
				if (!fb.trip && resetRise)
					state_next = dsc_pkg::ST_START_DISABLED;
			end
		endcase
	end

	// state, contactor timer and reset edge history
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg     <= dsc_pkg::ST_START_DISABLED;
			timer_reg     <= '0;
			resetPrev_reg <= 1'b0;
		end
		else
		begin
			state_reg     <= state_next;
			resetPrev_reg <= faultClr;
			// counts only while held in switched on; saturates at timeout
			if (state_reg != dsc_pkg::ST_SWITCHED_ON || state_next != state_reg)
				timer_reg <= '0;
			else if (!contactTmo)
				timer_reg <= timer_reg + 32'h1;
		end
	end

	// sequencer outputs decoded from the state
	wire inStartDis = (state_reg == dsc_pkg::ST_START_DISABLED);
	wire inTrip     = (state_reg == dsc_pkg::ST_TRIP_ACTIVE)
	               || (state_reg == dsc_pkg::ST_TRIPPED);
	wire startOk    = !inStartDis && (state_reg != dsc_pkg::ST_TRIPPED);
	wire switchedOn = !inStartDis && (state_reg != dsc_pkg::ST_START_ENABLED)
	               && (state_reg != dsc_pkg::ST_TRIPPED);
	wire running    = (state_reg == dsc_pkg::ST_ENABLED);
	wire remoteOk   = remoteMode & config_reg[dsc_pkg::CF_COMMS_SEL];
	wire limitHit   = fb.vectorMode ? fb.torqueLimit : fb.currentLimit;

	// status word assembly
	always_comb
	begin
		status_next = 16'h0000;
		status_next[dsc_pkg::SW_START_OK] = startOk;
		status_next[dsc_pkg::SW_SWITCHED] = switchedOn;
		status_next[dsc_pkg::SW_RUNNING]  = running;
		status_next[dsc_pkg::SW_FAULT]    = inTrip;
		status_next[dsc_pkg::SW_NOT_COAST] = remoteMode ?
			control_reg[dsc_pkg::CW_NOT_COAST] : loc.notCoastStop;
		status_next[dsc_pkg::SW_NOT_QUICK] = remoteMode ?
			control_reg[dsc_pkg::CW_NOT_QUICK] : loc.notFastStop;
		status_next[dsc_pkg::SW_INHIBIT]  = inStartDis;
		status_next[dsc_pkg::SW_REMOTE]   = remoteOk;
		status_next[dsc_pkg::SW_SETPOINT] = fb.rampIdle;
		status_next[dsc_pkg::SW_LIMIT]    = limitHit;
	end

	// bus decode; one wait cycle then answer
	wire busReq   = read | write;
	wire hitCtl   = (address == dsc_pkg::OFF_CONTROL);
	wire hitStat  = (address == dsc_pkg::OFF_STATUS);
	wire hitState = (address == dsc_pkg::OFF_STATE);
	wire hitCfg   = (address == dsc_pkg::OFF_CONFIG);
	wire doWrite  = write & ack_reg;
	// unmapped words read zero, writes dropped
	wire [31:0] readMux = hitCtl   ? {16'h0000, control_reg}
	                    : hitStat  ? {16'h0000, status_next}
	                    : hitState ? {29'h0, state_reg}
	                    : hitCfg   ? {29'h0, config_reg}
	                    : 32'h0000_0000;

	// ack toggles so each request gets exactly one low waitrequest
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			ack_reg <= 1'b0;
		else
			ack_reg <= busReq & ~ack_reg;
	end

	// registers written by software; the remote controller owns bits 4-6,10
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			control_reg <= dsc_pkg::CONTROL_RESET;
			config_reg  <= dsc_pkg::CONFIG_RESET;
		end
		else if (doWrite && hitCtl)
			control_reg <= writedata[15:0];
		else if (doWrite && hitCfg)
			config_reg  <= writedata[2:0];
	end

	// registered outputs
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			readdata    <= 32'h0000_0000;
			waitrequest <= 1'b1;
			seqState    <= 3'h0;
			statusWord  <= 16'h0000;
		end
		else
		begin
			readdata    <= readMux;
			waitrequest <= ~(busReq & ~ack_reg);
			seqState    <= state_next;
			statusWord  <= status_next;
		end
	end
endmodule // dsc_sequencer

// ==== design/dsc_pkg.sv ====
// package for the drive sequencing control word block
// assumes one 20 MHz clock and an Avalon-MM register slave
package dsc_pkg;
	// sequencing states, in reported order
	typedef enum logic [2:0] {
		ST_START_DISABLED,
		ST_START_ENABLED,
		ST_SWITCHED_ON,
		ST_READY,
		ST_ENABLED,
		ST_FSTOP_ACTIVE,
		ST_TRIP_ACTIVE,
		ST_TRIPPED
	} dsc_state_e;

	// register word offsets (byte addresses)
	localparam logic [3:0] OFF_CONTROL = 4'h0;
	localparam logic [3:0] OFF_STATUS  = 4'h4;
	localparam logic [3:0] OFF_STATE   = 4'h8;
	localparam logic [3:0] OFF_CONFIG  = 4'hc;

	// control word field positions
	localparam int CW_SWITCH_ON  = 0;
	localparam int CW_NOT_COAST  = 1;
	localparam int CW_NOT_QUICK  = 2;
	localparam int CW_ENABLE_OP  = 3;
	localparam int CW_FAULT_CLR  = 7;

	// status word field positions
	localparam int SW_START_OK   = 0;
	localparam int SW_SWITCHED   = 1;
	localparam int SW_RUNNING    = 2;
	localparam int SW_FAULT      = 3;
	localparam int SW_NOT_COAST  = 4;
	localparam int SW_NOT_QUICK  = 5;
	localparam int SW_INHIBIT    = 6;
	localparam int SW_REMOTE     = 9;
	localparam int SW_SETPOINT   = 10;
	localparam int SW_LIMIT      = 11;

	// config register field positions
	localparam int CF_REMOTE_MODE = 0;
	localparam int CF_COMMS_SEL   = 1;
	localparam int CF_COAST_FSTOP = 2;

	// reset values
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [2:0]  CONFIG_RESET  = 3'h0;

	// contactor close timeout
	localparam int CLK_HZ            = 20000000;
	localparam int CONTACTOR_TMO_S   = 10;
	localparam int CONTACTOR_TMO_CYC = CLK_HZ * CONTACTOR_TMO_S;

	// local sequencing inputs grouped together
	typedef struct packed {
		logic forwardMotion;   // run request
		logic inchRequest;     // jog request
		logic notCoastStop;    // coast-stop release
		logic notFastStop;     // fast-stop release
		logic driveEnable;     // enable request
		logic faultClear;      // trip reset
	} dsc_cmd_s;

	// plant feedback flags grouped together
	typedef struct packed {
		logic trip;            // any trip source
		logic contactorClosed; // contactor feedback
		logic defluxed;        // motor deflux done
		logic stopDone;        // stopping sequence complete
		logic fastStopExpired; // fast-stop timer expired
		logic atZeroSetpoint;  // drive at zero setpoint
		logic stackQuenched;   // power stack off
		logic rampIdle;        // reference ramp not ramping
		logic vectorMode;      // vector control selected
		logic torqueLimit;     // speed loop at torque limit
		logic currentLimit;    // open loop current limit
	} dsc_fb_s;
endpackage

// ==== tb/dsc_sequencer_sva.sv ====
// port checker for the drive sequencer
// assumes binding onto dsc_sequencer; status word lags state by one cycle
`timescale 1ns/1ns
module dsc_sequencer_sva (
	input wire logic              clock,
	input wire logic              resetn,
	input wire logic [3:0]        address,
	input wire logic              read,
	input wire logic              write,
	input wire logic [31:0]       writedata,
	input wire logic [31:0]       readdata,
	input wire logic              waitrequest,
	input wire dsc_pkg::dsc_cmd_s localCmd,
	input wire dsc_pkg::dsc_fb_s  plantFb,
	input wire logic [2:0]        seqState,
	input wire logic [15:0]       statusWord
);
	// one domain, so clock and reset given once
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	// $past(resetn) skips the first edge, where status still holds its reset value
	inhibit_bit_a: assert property ($past(resetn) |-> statusWord[6] == ($past(seqState) == 3'h0))
		else $error("switch-on inhibit bit wrong");
	fault_bit_a: assert property ($past(resetn) |-> statusWord[3] == ($past(seqState) >= 3'h6))
		else $error("fault bit wrong");
	running_bit_a: assert property ($past(resetn) |-> statusWord[2] == ($past(seqState) == 3'h4))
		else $error("running bit wrong");
	unused_bits_a: assert property ({statusWord[15:12], statusWord[8:7]} == 6'h0)
		else $error("unsupported status bits set");
	disabled_exit_a: assert property (seqState == 3'h0 |=> seqState inside {3'h0, 3'h1, 3'h6})
		else $error("bad exit from start disabled");
	trip_exit_a: assert property (seqState == 3'h6 |=> seqState inside {3'h6, 3'h7})
		else $error("bad exit from trip active");
	tripped_exit_a: assert property (seqState == 3'h7 |=> seqState inside {3'h7, 3'h0})
		else $error("bad exit from tripped");
	bus_answer_a: assert property ($fell(waitrequest) |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	// four stable samples cover the two sync stages plus the status register
	limit_bit_a: assert property ($stable(plantFb)[*4] ##0 $past(resetn, 5) |->
		statusWord[11] == (plantFb.vectorMode ? plantFb.torqueLimit : plantFb.currentLimit))
		else $error("internal limit bit wrong");
endmodule // dsc_sequencer_sva

// ==== tb/dsc_remote_ctrl.sv ====
// remote controller model: avalon master writing command words
// assumes a slave that answers with waitrequest low; waits bounded
`timescale 1ns/1ns
module dsc_remote_ctrl (
	input  wire logic        clock,
	output logic [3:0]       address,
	output logic             read,
	output logic             write,
	output logic [31:0]      writedata,
	input  wire logic [31:0] readdata,
	input  wire logic        waitrequest
);
	int busErrs; // transfers never answered
	// idle bus from time zero
	initial
	begin
		busErrs = 0;
		address = 4'h0;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
	end
	// one transfer; extra edge first so back-to-back calls never retoggle in one step
	task automatic xfer(input logic [3:0] a, input logic wr, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clock);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= d;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		q = readdata;
		if (n >= 50)
			busErrs++;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	// command word; reserved bits forced to their fixed levels
	task automatic command(input logic [15:0] ctl);
		logic [31:0] q;
		xfer(dsc_pkg::OFF_CONTROL, 1'b1, {16'h0, (ctl & 16'h008f) | 16'h0470}, q);
	endtask
endmodule // dsc_remote_ctrl

// ==== tb/tb.sv ====
// testbench for the drive sequencer, local then remote control, then local stops
// assumes a short contactor timeout so the trip path runs quickly
`timescale 1ns/1ns
module tb;
	logic              clock;
	logic              resetn;
	logic [3:0]        address;
	logic              read;
	logic              write;
	logic [31:0]       writedata;
	logic [31:0]       readdata;
	logic              waitrequest;
	dsc_pkg::dsc_cmd_s localCmd;
	dsc_pkg::dsc_fb_s  plantFb;
	logic [2:0]        seqState;
	logic [15:0]       statusWord;
	logic [31:0]       rdVal;
	int                failures;
	int                tests_run;

	dsc_sequencer #(.CONTACTOR_TMO(20)) uut (.clock(clock), .resetn(resetn), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .localCmd(localCmd), .plantFb(plantFb),
		.seqState(seqState), .statusWord(statusWord));
	dsc_remote_ctrl plc (.clock(clock), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));

	// 50 ns clock
	always #25 clock = ~clock;

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		if (failures == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// bounded wait for a state, then compare
	task automatic reach(input logic [2:0] exp);
		int n;
		n = 0;
		while (seqState !== exp && n < 40)
		begin
			@(posedge clock);
			n++;
		end
		check("seqState", {29'h0, seqState}, {29'h0, exp});
	endtask
	// status word once it has caught up with the state
	task automatic status(input logic [15:0] mask, input logic [15:0] exp);
		repeat (3) @(posedge clock);
		check("statusWord", {16'h0, statusWord & mask}, {16'h0, exp});
	endtask

	// register reset, readback, unmapped and read-only places
	task automatic t_regs();
		reach(3'h1);
		plc.xfer(dsc_pkg::OFF_CONTROL, 1'b0, 32'h0, rdVal);
		check("control reset", rdVal, 32'h0);
		plc.command(16'h007e);
		plc.xfer(dsc_pkg::OFF_CONTROL, 1'b0, 32'h0, rdVal);
		check("control word", rdVal, 32'h047e);
		plc.xfer(4'h2, 1'b1, 32'hffff, rdVal);
		plc.xfer(4'h2, 1'b0, 32'h0, rdVal);
		check("unmapped", rdVal, 32'h0);
		plc.xfer(dsc_pkg::OFF_STATUS, 1'b1, 32'hffff, rdVal);
		plc.xfer(dsc_pkg::OFF_STATUS, 1'b0, 32'h0, rdVal);
		check("status read", rdVal, 32'h0031);
	endtask
	// contactor never closes: timeout trip, quench, guarded reset
	task automatic t_trip();
		localCmd.forwardMotion <= 1'b1;
		reach(3'h2);
		repeat (10) @(posedge clock);
		check("no early trip", {29'h0, seqState}, 32'h2);
		reach(3'h6);
		status(16'h004f, 16'h000b);
		plantFb.stackQuenched <= 1'b1;
		reach(3'h7);
		plantFb.trip <= 1'b1;
		localCmd.faultClear <= 1'b1;
		repeat (8) @(posedge clock);
		check("reset while trip", {29'h0, seqState}, 32'h7);
		localCmd.faultClear <= 1'b0;
		plantFb.trip <= 1'b0;
		repeat (4) @(posedge clock);
		localCmd.faultClear <= 1'b1;
		reach(3'h0);
		plantFb.stackQuenched <= 1'b0;
		localCmd.faultClear <= 1'b0;
		localCmd.forwardMotion <= 1'b0;
		reach(3'h1);
	endtask
	// full local walk up to enabled and out through fast stop
	task automatic t_run();
		plantFb.contactorClosed <= 1'b1;
		plantFb.defluxed <= 1'b1;
		localCmd.forwardMotion <= 1'b1;
		reach(3'h3);
		localCmd.forwardMotion <= 1'b0;
		reach(3'h1);
		localCmd.forwardMotion <= 1'b1;
		reach(3'h3);
		localCmd.driveEnable <= 1'b1;
		reach(3'h4);
		status(16'h004f, 16'h0007);
		localCmd.driveEnable <= 1'b0;
		reach(3'h3);
		localCmd.driveEnable <= 1'b1;
		reach(3'h4);
		localCmd.notFastStop <= 1'b0;
		reach(3'h5);
		plantFb.atZeroSetpoint <= 1'b1;
		reach(3'h0);
		status(16'h0070, 16'h0050);
		localCmd.notFastStop <= 1'b1;
		plantFb.atZeroSetpoint <= 1'b0;
		localCmd.forwardMotion <= 1'b0;
		localCmd.driveEnable <= 1'b0;
		reach(3'h1);
	endtask
	// remote mode: local run ignored, command word drives, echoes in status
	task automatic t_remote();
		plc.xfer(dsc_pkg::OFF_CONFIG, 1'b1, 32'h3, rdVal);
		localCmd.forwardMotion <= 1'b1;
		plantFb.rampIdle <= 1'b1;
		plantFb.vectorMode <= 1'b1;
		plantFb.torqueLimit <= 1'b1;
		repeat (6) @(posedge clock);
		check("local run ignored", {29'h0, seqState}, 32'h1);
		status(16'h0e30, 16'h0e30);
		plc.command(16'h000f);
		reach(3'h2);
		plc.command(16'h000b);
		reach(3'h0);
		status(16'h0030, 16'h0010);
	endtask
	// remote enable gate, limit source, remote fault clear, back to local
	task automatic t_remote_run();
		plc.command(16'h000e);
		reach(3'h1);
		plc.command(16'h000f);
		reach(3'h3);
		repeat (6) @(posedge clock);
		check("enable gated", {29'h0, seqState}, 32'h3);
		localCmd.driveEnable <= 1'b1;
		reach(3'h4);
		// open-loop mode: torque limit must no longer show
		plantFb.vectorMode <= 1'b0;
		plantFb.currentLimit <= 1'b0;
		repeat (2) @(posedge clock);
		status(16'h0800, 16'h0000);
		plantFb.currentLimit <= 1'b1;
		repeat (2) @(posedge clock);
		status(16'h0800, 16'h0800);
		plantFb.trip <= 1'b1;
		reach(3'h6);
		plantFb.stackQuenched <= 1'b1;
		reach(3'h7);
		plantFb.trip <= 1'b0;
		localCmd.faultClear <= 1'b1;
		repeat (6) @(posedge clock);
		check("local reset ignored", {29'h0, seqState}, 32'h7);
		plc.command(16'h008f);
		reach(3'h0);
		plantFb.stackQuenched <= 1'b0;
		localCmd.faultClear <= 1'b0;
		localCmd.forwardMotion <= 1'b0;
		localCmd.driveEnable <= 1'b0;
		plc.command(16'h000e);
		reach(3'h1);
		plc.xfer(dsc_pkg::OFF_CONFIG, 1'b1, 32'h0, rdVal);
	endtask
	// local stop priority, jog, stop completion, fast-stop exits, contactor loss
	task automatic t_stops();
		localCmd.notCoastStop <= 1'b0;
		reach(3'h0);
		localCmd.notCoastStop <= 1'b1;
		reach(3'h1);
		localCmd.inchRequest <= 1'b1;
		reach(3'h3);
		localCmd.driveEnable <= 1'b1;
		reach(3'h4);
		// both stops at once: coast has the lower number, so no fast stop
		localCmd.notCoastStop <= 1'b0;
		localCmd.notFastStop <= 1'b0;
		reach(3'h0);
		localCmd.notCoastStop <= 1'b1;
		localCmd.notFastStop <= 1'b1;
		localCmd.inchRequest <= 1'b0;
		reach(3'h1);
		localCmd.inchRequest <= 1'b1;
		reach(3'h4);
		localCmd.inchRequest <= 1'b0;
		repeat (8) @(posedge clock);
		check("stop not done", {29'h0, seqState}, 32'h4);
		plantFb.stopDone <= 1'b1;
		reach(3'h1);
		plantFb.stopDone <= 1'b0;
		localCmd.forwardMotion <= 1'b1;
		reach(3'h4);
		localCmd.notFastStop <= 1'b0;
		reach(3'h5);
		repeat (8) @(posedge clock);
		check("fast stop held", {29'h0, seqState}, 32'h5);
		plantFb.fastStopExpired <= 1'b1;
		reach(3'h0);
		plantFb.fastStopExpired <= 1'b0;
		localCmd.notFastStop <= 1'b1;
		localCmd.forwardMotion <= 1'b0;
		reach(3'h1);
		// coast method: fast stop lasts a single cycle
		plc.xfer(dsc_pkg::OFF_CONFIG, 1'b1, 32'h4, rdVal);
		localCmd.forwardMotion <= 1'b1;
		reach(3'h4);
		localCmd.notFastStop <= 1'b0;
		reach(3'h5);
		reach(3'h0);
		localCmd.notFastStop <= 1'b1;
		localCmd.forwardMotion <= 1'b0;
		reach(3'h1);
		localCmd.forwardMotion <= 1'b1;
		reach(3'h4);
		plantFb.contactorClosed <= 1'b0;
		reach(3'h6);
		plantFb.stackQuenched <= 1'b1;
		reach(3'h7);
		localCmd.faultClear <= 1'b1;
		reach(3'h0);
	endtask

	// reset, scenarios, verdict
	initial
	begin
		clock = 1'b0;
		resetn = 1'b0;
		localCmd = 6'h0c;
		plantFb = 11'h0;
		failures = 0;
		tests_run = 0;
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		t_regs();
		t_trip();
		t_run();
		t_remote();
		t_remote_run();
		t_stops();
		check("bus answers", plc.busErrs, 32'h0);
		summarize();
	end
	// watchdog, well past the few hundred cycles the scenarios need
	initial
	begin
		#1000000;
		failures++;
		summarize();
	end
endmodule // tb

bind dsc_sequencer dsc_sequencer_sva chk (.clock(clock), .resetn(resetn), .address(address),
	.read(read), .write(write), .writedata(writedata), .readdata(readdata),
	.waitrequest(waitrequest), .localCmd(localCmd), .plantFb(plantFb),
	.seqState(seqState), .statusWord(statusWord));
